/* src/arx_slot_consts.vh */
/*
  Constants for the receive slot configuration block: register indices,
  field positions, reset values and link sizes.
  Assumes APB byte address = register index * 4.
*/
// Behaviour
// - Start bit 8 from start-high bit 0
// - Start bits 7:0 from start-low register
// - Position counted from frame edge plus lag
// - Active level only in half-frame, single rate
// - Level 0 captures while frame clock low
// - Level 1 captures while frame clock high
// - Width 01 is 16, 10 is 24 bits
// - Width 11 is 32 bits, reset default
// - Active level resets to low
// - Double-rate bit doubles receive sample rate
// - Buffer filled only from samples started while channel enabled
`ifndef ARX_SLOT_CONSTS_VH
`define ARX_SLOT_CONSTS_VH

`define ARX_IDX_ENABLE     14'h2A01
`define ARX_IDX_CH1_LW     14'h2A02
`define ARX_IDX_CH1_STH    14'h2A03
`define ARX_IDX_CH1_STL    14'h2A04
`define ARX_IDX_CH2_LW     14'h2A05
`define ARX_IDX_CH2_STH    14'h2A06
`define ARX_IDX_CH2_STL    14'h2A07
`define ARX_IDX_CH3_LW     14'h2A08
`define ARX_IDX_CH3_STH    14'h2A09
`define ARX_IDX_CH3_STL    14'h2A0A
`define ARX_IDX_CTRL       14'h2A10
`define ARX_IDX_STATUS     14'h2A11

`define ARX_EN_DBL_BIT     0
`define ARX_EN_CH1_BIT     2
`define ARX_LW_LEVEL_BIT   6
`define ARX_LW_WIDTH_LSB   0
`define ARX_CTRL_HALF_BIT  0
`define ARX_CTRL_LAG_LSB   1
`define ARX_ST_OVF_BIT     8
`define ARX_ST_BUSY_LSB    9

`define ARX_WIDTH_RESET    2'h3
`define ARX_LEVEL_RESET    1'h0
`define ARX_START_RESET    9'h000
`define ARX_LAG_RESET      4'h0

`define ARX_NUM_CH         3
`define ARX_FIFO_WIDTH     34
`define ARX_FIFO_DEPTH     16
`define ARX_FIFO_AW        4
`define ARX_POS_MAX        9'h1FF

`endif

/* src/arx_slot_rx.v */
/*
  Receive interface zero, channels 1 to 3: slot configuration registers on
  APB, serial capture from bit clock, frame clock and data pins, and a
  16-word FIFO for captured samples. Pins are asynchronous to ref_clk and
  the bit clock must be well below a quarter of ref_clk.
*/
// Chosen here: the APB register port.
`timescale 1ns/1ns
`include "arx_slot_consts.vh"

module arx_fifo #(
  parameter WIDTH = 34,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire             ref_clk,
  input  wire             rst,
  // Fill side
  input  wire             inValid,
  output wire             inReady,
  input  wire [WIDTH-1:0] inData,
  // Drain side
  output reg              outValid_q,
  input  wire             outReady,
  output reg  [WIDTH-1:0] outData_q,
  // Level
  output reg  [AW:0]      count_q
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wrPtr_q;
  reg [AW-1:0]    rdPtr_q;
  wire            push;
  wire            pop;

  assign inReady = (count_q != DEPTH[AW:0]);
  assign push    = inValid & inReady;
  // Output stage refills whenever it is empty or being taken
  assign pop     = (count_q != {(AW+1){1'b0}}) & (~outValid_q | outReady);

  always @(posedge ref_clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wrPtr_q    <= {AW{1'b0}};
      rdPtr_q    <= {AW{1'b0}};
      count_q    <= {(AW+1){1'b0}};
      outValid_q <= 1'b0;
      outData_q  <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q   <= rdPtr_q + 1'b1;
        outData_q <= mem[rdPtr_q];
      end
      if (pop) begin
        outValid_q <= 1'b1;
      end else if (outReady) begin
        outValid_q <= 1'b0;
      end
      count_q <= count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

module arx_slot_rx (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [15:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata_q,
  output reg         pready_q,
  output reg         pslverr_q,
  // Serial pins
  input  wire        bitClk,
  input  wire        frameSelectClock,
  input  wire        serialData,
  // Sample stream
  output wire        sampleValid,
  input  wire        sampleReady,
  output wire [33:0] sampleWord
);
  // Configuration
  reg  [2:0]  chEnable_q;
  reg         doubleRateSel_q;
  reg  [2:0]  activeLevel_q;
  reg  [5:0]  sampleWidth_q;
  reg  [2:0]  startHigh_q;
  reg  [23:0] startLow_q;
  reg         halfFrameModeSel_q;
  reg  [3:0]  phaseLag_q;
  reg         overflow_q;
  // Pin synchronisers and edge history
  reg  [1:0]  bclkSync_q;
  reg  [1:0]  fclkSync_q;
  reg  [1:0]  dataSync_q;
  reg         bclkPrev_q;
  reg         fclkPrev_q;
  // Slot position
  reg  [8:0]  bitCnt_q;
  reg  [3:0]  lagRem_q;
  // Per-channel capture
  reg  [31:0] shift_q [0:2];
  reg  [31:0] hold_q [0:2];
  reg  [5:0]  got_q [0:2];
  reg  [2:0]  busy_q;
  reg  [2:0]  pend_q;
  reg  [1:0]  pushCh;
  reg  [31:0] rdMux;
  reg         rdHit;
  wire [4:0]  fifoCount;
  wire        fifoReady;
  wire        bitTick;
  wire        frameEdge;
  wire        sofEdge;
  wire        levelGate;
  wire [3:0]  lagNow;
  wire [8:0]  posNow;
  wire        bitValid;
  wire        apbSetup;
  wire        apbWrite;
  wire [13:0] regIdx;
  wire        idxAligned;
  wire        pushAny;
  integer     i;

  // Sample length in bits for a width code
  function [5:0] widthBits;
    input [1:0] code;
    begin
      case (code)
        2'h0:    widthBits = 6'h08;
        2'h1:    widthBits = 6'h10;
        2'h2:    widthBits = 6'h18;
        default: widthBits = 6'h20;
      endcase
    end
  endfunction

  // Level and width register image
  function [31:0] levelWidthImage;
    input       level;
    input [1:0] width;
    begin
      levelWidthImage = 32'h0000_0000;
      levelWidthImage[`ARX_LW_LEVEL_BIT] = level;
      levelWidthImage[`ARX_LW_WIDTH_LSB +: 2] = width;
    end
  endfunction

  assign regIdx     = paddr[15:2];
  assign idxAligned = (paddr[1:0] == 2'h0);
  assign apbSetup   = psel & ~penable;
  assign apbWrite   = psel & penable & pready_q & pwrite & ~pslverr_q;

  always @* begin
    rdMux = 32'h0000_0000;
    rdHit = idxAligned;
    case (regIdx)
      `ARX_IDX_ENABLE: begin
        rdMux[`ARX_EN_DBL_BIT] = doubleRateSel_q;
        rdMux[`ARX_EN_CH1_BIT +: 3] = chEnable_q;
      end
      `ARX_IDX_CH1_LW:  rdMux = levelWidthImage(activeLevel_q[0], sampleWidth_q[1:0]);
      `ARX_IDX_CH2_LW:  rdMux = levelWidthImage(activeLevel_q[1], sampleWidth_q[3:2]);
      `ARX_IDX_CH3_LW:  rdMux = levelWidthImage(activeLevel_q[2], sampleWidth_q[5:4]);
      `ARX_IDX_CH1_STH: rdMux[0] = startHigh_q[0];
      `ARX_IDX_CH2_STH: rdMux[0] = startHigh_q[1];
      `ARX_IDX_CH3_STH: rdMux[0] = startHigh_q[2];
      `ARX_IDX_CH1_STL: rdMux[7:0] = startLow_q[7:0];
      `ARX_IDX_CH2_STL: rdMux[7:0] = startLow_q[15:8];
      `ARX_IDX_CH3_STL: rdMux[7:0] = startLow_q[23:16];
      `ARX_IDX_CTRL: begin
        rdMux[`ARX_CTRL_HALF_BIT] = halfFrameModeSel_q;
        rdMux[`ARX_CTRL_LAG_LSB +: 4] = phaseLag_q;
      end
      `ARX_IDX_STATUS: begin
        rdMux[4:0] = fifoCount;
        rdMux[`ARX_ST_OVF_BIT] = overflow_q;
        rdMux[`ARX_ST_BUSY_LSB +: 3] = busy_q;
      end
      default: rdHit = 1'b0;
    endcase
  end

  // Registered answer: one access cycle, error on unmapped word
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= apbSetup;
      pslverr_q <= apbSetup & ~rdHit;
      if (apbSetup) begin
        prdata_q <= rdHit & ~pwrite ? rdMux : 32'h0000_0000;
      end
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      chEnable_q         <= 3'h0;
      doubleRateSel_q    <= 1'b0;
      activeLevel_q      <= {3{`ARX_LEVEL_RESET}};
      sampleWidth_q      <= {3{`ARX_WIDTH_RESET}};
      startHigh_q        <= 3'h0;
      startLow_q         <= 24'h00_0000;
      halfFrameModeSel_q <= 1'b0;
      phaseLag_q         <= `ARX_LAG_RESET;
    end else if (apbWrite) begin
      case (regIdx)
        `ARX_IDX_ENABLE: begin
          doubleRateSel_q <= pwdata[`ARX_EN_DBL_BIT];
          chEnable_q      <= pwdata[`ARX_EN_CH1_BIT +: 3];
        end
        `ARX_IDX_CH1_LW: begin
          activeLevel_q[0]   <= pwdata[`ARX_LW_LEVEL_BIT];
          sampleWidth_q[1:0] <= pwdata[`ARX_LW_WIDTH_LSB +: 2];
        end
        `ARX_IDX_CH2_LW: begin
          activeLevel_q[1]   <= pwdata[`ARX_LW_LEVEL_BIT];
          sampleWidth_q[3:2] <= pwdata[`ARX_LW_WIDTH_LSB +: 2];
        end
        `ARX_IDX_CH3_LW: begin
          activeLevel_q[2]   <= pwdata[`ARX_LW_LEVEL_BIT];
          sampleWidth_q[5:4] <= pwdata[`ARX_LW_WIDTH_LSB +: 2];
        end
        // start bit 8 lives in bit 0
        `ARX_IDX_CH1_STH: startHigh_q[0] <= pwdata[0];
        `ARX_IDX_CH2_STH: startHigh_q[1] <= pwdata[0];
        `ARX_IDX_CH3_STH: startHigh_q[2] <= pwdata[0];
        `ARX_IDX_CH1_STL: startLow_q[7:0]   <= pwdata[7:0];
        `ARX_IDX_CH2_STL: startLow_q[15:8]  <= pwdata[7:0];
        `ARX_IDX_CH3_STL: startLow_q[23:16] <= pwdata[7:0];
        `ARX_IDX_CTRL: begin
          halfFrameModeSel_q <= pwdata[`ARX_CTRL_HALF_BIT];
          phaseLag_q         <= pwdata[`ARX_CTRL_LAG_LSB +: 4];
        end
        default: begin
        end
      endcase
    end
  end

  // Two flops per pin before any logic looks at them
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bclkSync_q <= 2'h0;
      fclkSync_q <= 2'h0;
      dataSync_q <= 2'h0;
      bclkPrev_q <= 1'b0;
    end else begin
      bclkSync_q <= {bclkSync_q[0], bitClk};
      fclkSync_q <= {fclkSync_q[0], frameSelectClock};
      dataSync_q <= {dataSync_q[0], serialData};
      bclkPrev_q <= bclkSync_q[1];
    end
  end

  assign bitTick   = bclkSync_q[1] & ~bclkPrev_q;
  assign frameEdge = fclkSync_q[1] ^ fclkPrev_q;
  // double rate starts a frame on both edges
  assign sofEdge   = frameEdge & (fclkSync_q[1] | halfFrameModeSel_q | doubleRateSel_q);
  // level honoured only in half-frame at single rate
  assign levelGate = halfFrameModeSel_q & ~doubleRateSel_q;
  // position from frame edge after lag
  assign lagNow    = sofEdge ? phaseLag_q : lagRem_q;
  assign posNow    = sofEdge ? `ARX_START_RESET : bitCnt_q;
  assign bitValid  = (lagNow == 4'h0);
  assign pushAny   = |pend_q;

  always @* begin
    if (pend_q[0]) begin
      pushCh = 2'h0;
    end else if (pend_q[1]) begin
      pushCh = 2'h1;
    end else begin
      pushCh = 2'h2;
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fclkPrev_q <= 1'b0;
      bitCnt_q   <= `ARX_START_RESET;
      lagRem_q   <= `ARX_LAG_RESET;
      busy_q     <= 3'h0;
      pend_q     <= 3'h0;
      overflow_q <= 1'b0;
      for (i = 0; i < `ARX_NUM_CH; i = i + 1) begin
        shift_q[i] <= 32'h0000_0000;
        hold_q[i]  <= 32'h0000_0000;
        got_q[i]   <= 6'h00;
      end
    end else begin
      if (pushAny) begin
        pend_q[pushCh] <= 1'b0;
      end
      // Clear by writing one; a new overflow in that cycle wins
      if (apbWrite && regIdx == `ARX_IDX_STATUS && pwdata[`ARX_ST_OVF_BIT]) begin
        overflow_q <= 1'b0;
      end
      if (pushAny && !fifoReady) begin
        overflow_q <= 1'b1;
      end
      if (bitTick) begin
        fclkPrev_q <= fclkSync_q[1];
        if (bitValid) begin
          lagRem_q <= 4'h0;
          bitCnt_q <= (posNow == `ARX_POS_MAX) ? posNow : posNow + 9'h001;
        end else begin
          lagRem_q <= lagNow - 4'h1;
          bitCnt_q <= posNow;
        end
        for (i = 0; i < `ARX_NUM_CH; i = i + 1) begin
          if (sofEdge) begin
            // A sample cut by a new frame is discarded
            busy_q[i] <= 1'b0;
          end
          if (bitValid && (busy_q[i] && !sofEdge)) begin
            shift_q[i] <= {shift_q[i][30:0], dataSync_q[1]};
            got_q[i]   <= got_q[i] + 6'h01;
            if (got_q[i] + 6'h01 == widthBits(sampleWidth_q[2*i +: 2])) begin
              busy_q[i] <= 1'b0;
              hold_q[i] <= {shift_q[i][30:0], dataSync_q[1]};
              pend_q[i] <= 1'b1;
              if (pend_q[i]) begin
                overflow_q <= 1'b1;
              end
            end
          end else if (bitValid && chEnable_q[i] && !(busy_q[i] && !sofEdge) &&
                       posNow == {startHigh_q[i], startLow_q[8*i +: 8]} &&
                       (!levelGate || fclkSync_q[1] == activeLevel_q[i])) begin
            shift_q[i] <= {31'h0000_0000, dataSync_q[1]};
            got_q[i]   <= 6'h01;
            busy_q[i]  <= 1'b1;
          end
        end
      end
    end
  end

  arx_fifo #(
    .WIDTH (`ARX_FIFO_WIDTH),
    .DEPTH (`ARX_FIFO_DEPTH),
    .AW    (`ARX_FIFO_AW)
  ) u_fifo (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .inValid    (pushAny),
    .inReady    (fifoReady),
    .inData     ({pushCh, hold_q[pushCh]}),
    .outValid_q (sampleValid),
    .outReady   (sampleReady),
    .outData_q  (sampleWord),
    .count_q    (fifoCount)
  );
endmodule

/* tb/arx_host_model.sv */
/*
  Behavioural serial host: drives bit clock, frame clock and data, one frame
  per call of send. Assumes the bench calls it; bit clock stands low between frames.
*/
`timescale 1ns/1ns

module arx_host_model (
  // Serial pins
  output logic bitClk,
  output logic frameSelectClock,
  output logic serialData
);
  initial begin
    bitClk = 1'b0;
    frameSelectClock = 1'b0;
    serialData = 1'b0;
  end

  // Data moves while the bit clock is low; offset keeps it off the system edge
  task automatic send(input logic [575:0] bits, input int n, input int half);
    #13;
    for (int p = 0; p < n; p++) begin
      serialData = bits[p];
      frameSelectClock = (p < half);
      #200 bitClk = 1'b1;
      #200 bitClk = 1'b0;
    end
    // Released line shows the inverse, so a stale bit cannot pass
    serialData = ~serialData;
  endtask
endmodule

/* tb/arx_slot_rx_properties.sv */
/*
  Checker for the receive slot block: APB answer timing, read masks of the
  slot registers, and the sample stream hold.
  Assumes it is bound to arx_slot_rx and that the constants header is on the path.
*/
`timescale 1ns/1ns
`include "arx_slot_consts.vh"

module arx_slot_rx_properties (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] prdata_q,
  input wire logic        pready_q,
  input wire logic        pslverr_q,
  // Sample stream
  input wire logic        sampleValid,
  input wire logic        sampleReady,
  input wire logic [33:0] sampleWord
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  wire        rdDone = pready_q && !pwrite;
  wire [13:0] idx    = paddr[15:2];

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_done;
    psel && penable && pready_q;
  endsequence

  property p_answer;
    s_setup |=> s_done;
  endproperty
  property p_pulse;
    pready_q |=> !pready_q;
  endproperty
  property p_err;
    pslverr_q |-> pready_q;
  endproperty
  property p_unalign;
    s_setup ##0 (paddr[1:0] != 2'h0) |=> s_done ##0 pslverr_q;
  endproperty
  property p_lw;
    rdDone && (idx inside {`ARX_IDX_CH1_LW, `ARX_IDX_CH2_LW, `ARX_IDX_CH3_LW})
      |-> prdata_q[31:7] == 25'h0 && prdata_q[5:2] == 4'h0;
  endproperty
  property p_sth;
    rdDone && (idx inside {`ARX_IDX_CH1_STH, `ARX_IDX_CH2_STH, `ARX_IDX_CH3_STH}) |-> prdata_q[31:1] == 31'h0;
  endproperty
  property p_stl;
    rdDone && (idx inside {`ARX_IDX_CH1_STL, `ARX_IDX_CH2_STL, `ARX_IDX_CH3_STL}) |-> prdata_q[31:8] == 24'h0;
  endproperty
  property p_hold;
    sampleValid && !sampleReady |=> sampleValid && $stable(sampleWord);
  endproperty
  property p_chan;
    sampleValid |-> sampleWord[33:32] != 2'h3;
  endproperty

  a_answer: assert property (p_answer) else $error("no answer in first access cycle");
  a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
  a_err: assert property (p_err) else $error("slave error without pready");
  a_unalign: assert property (p_unalign) else $error("unaligned access not refused");
  a_lw: assert property (p_lw) else $error("reserved level width bits read nonzero");
  a_sth: assert property (p_sth) else $error("start high reads beyond bit 0");
  a_stl: assert property (p_stl) else $error("start low reads beyond 8 bits");
  a_hold: assert property (p_hold) else $error("stalled sample changed");
  a_chan: assert property (p_chan) else $error("sample channel out of range");
endmodule

bind arx_slot_rx arx_slot_rx_properties u_props (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .prdata_q,
  .pready_q, .pslverr_q, .sampleValid, .sampleReady, .sampleWord);

/* tb/arx_slot_rx_tb.sv */
/*
  Testbench for arx_slot_rx: register table rows, capture per width code,
  half-frame levels, double rate, disabled channel and FIFO fill.
  Assumes the host model and the bound checker.
*/
`timescale 1ns/1ns

module arx_slot_rx_tb;
  typedef struct packed {
    logic [15:0] addr;
    logic        wr;
    logic [31:0] wd;
    logic [31:0] exp;
    logic        err;
  } arx_row_t;

  logic         ref_clk, rst, psel, penable, pwrite, sampleReady, er;
  logic         pready_q, pslverr_q, bitClk, frameSelectClock, serialData, sampleValid;
  logic [15:0]  paddr;
  logic [31:0]  pwdata, prdata_q, rd;
  logic [33:0]  sampleWord, w;
  logic [575:0] frm;
  int           num_errors = 0;
  int           checks = 0;

  arx_row_t rows [9] = '{
    // width 32 and level low after reset
    '{16'hA808, 1'b0, 32'h0, 32'h3, 1'b0},
    '{16'hA814, 1'b0, 32'h0, 32'h3, 1'b0},
    '{16'hA820, 1'b0, 32'h0, 32'h3, 1'b0},
    '{16'hA80C, 1'b0, 32'h0, 32'h0, 1'b0},
    '{16'hA80C, 1'b1, 32'hFFFFFFFF, 32'h1, 1'b0},
    '{16'hA810, 1'b1, 32'h000001FF, 32'hFF, 1'b0},
    '{16'hA814, 1'b1, 32'hFFFFFFFF, 32'h43, 1'b0},
    '{16'h0000, 1'b1, 32'hFFFFFFFF, 32'h0, 1'b1},
    '{16'hA809, 1'b0, 32'h0, 32'h0, 1'b1}};

  arx_slot_rx DUT (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_q, .pready_q, .pslverr_q,
    .bitClk, .frameSelectClock, .serialData, .sampleValid, .sampleReady, .sampleWord);
  arx_host_model host (.bitClk, .frameSelectClock, .serialData);

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge ref_clk);
    end while (pready_q !== 1'b1);
    rd = prdata_q;
    er = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic getw();
    @(posedge ref_clk);
    sampleReady <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (sampleValid !== 1'b1);
    w = sampleWord;
    sampleReady <= 1'b0;
  endtask

  task automatic place(input int p, input logic [31:0] v, input int n);
    for (int i = 0; i < n; i++) frm[p + i] = v[n - 1 - i];
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #2000000;
    num_errors++;
    report_and_stop();
  end

  initial begin
    {psel, penable, pwrite, sampleReady, paddr, pwdata} = '0;
    rst = 1'b1;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    chk("sampleValid", 34'(sampleValid), 34'h0);
    foreach (rows[i]) begin
      if (rows[i].wr) apb(1'b1, rows[i].addr, rows[i].wd);
      apb(1'b0, rows[i].addr, 32'h0);
      chk("rdata", 34'(rd), 34'(rows[i].exp));
      chk("slverr", 34'(er), 34'(rows[i].err));
    end
    $display("test registers done");
    // all width codes, lag and start bit 8
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, 16'hA840, 32'(c) << 1);
      apb(1'b1, 16'hA804, 32'h4);
      apb(1'b1, 16'hA808, 32'(c));
      apb(1'b1, 16'hA80C, 32'h1);
      apb(1'b1, 16'hA810, 32'h1);
      frm = {288{2'b01}};
      place(c + 257, 32'hC3A596E1, 8 * (c + 1));
      host.send(frm, c + 300, 150);
      getw();
      chk("ch1 sample", w, 34'hC3A596E1 & ((34'h1 << (8 * (c + 1))) - 34'h1));
    end
    $display("test widths done");
    apb(1'b1, 16'hA840, 32'h1);
    apb(1'b1, 16'hA80C, 32'h0);
    apb(1'b1, 16'hA818, 32'h0);
    apb(1'b1, 16'hA81C, 32'h2);
    frm = {288{2'b01}};
    place(2, 32'hA55A, 16);
    place(22, 32'h3CC3, 16);
    // last pass adds double rate, so the level is ignored
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, 16'hA804, m == 2 ? 32'h9 : 32'h8);
      apb(1'b1, 16'hA814, m == 0 ? 32'h1 : 32'h41);
      host.send(frm, 40, 20);
      getw();
      chk("half sample", w, {2'h1, 16'h0, m == 0 ? 16'h3CC3 : 16'hA55A});
      if (m == 2) begin
        getw();
        chk("second half", w, {2'h1, 16'h0, 16'h3CC3});
      end
    end
    $display("test half frame done");
    apb(1'b1, 16'hA804, 32'h0);
    host.send(frm, 40, 20);
    repeat (20) @(posedge ref_clk);
    chk("disabled", 34'(sampleValid), 34'h0);
    $display("test disabled done");
    apb(1'b1, 16'hA840, 32'h0);
    apb(1'b1, 16'hA804, 32'h1C);
    for (int c = 0; c < 3; c++) begin
      apb(1'b1, 16'hA808 + 16'(12 * c), 32'h0);
      apb(1'b1, 16'hA810 + 16'(12 * c), 32'(8 * c));
    end
    // Six frames of three samples overrun 16 words plus the output stage
    for (int k = 0; k < 6; k++) begin
      frm = {288{2'b01}};
      for (int c = 0; c < 3; c++) place(8 * c, 32'(64 * c + k), 8);
      host.send(frm, 26, 13);
    end
    apb(1'b0, 16'hA844, 32'h0);
    chk("status full", 34'(rd[8:0]), 34'h110);
    // Output stage holds a seventeenth word; only the third sample of frame six is lost
    for (int i = 0; i < 17; i++) begin
      getw();
      chk("fifo word", w, {2'(i % 3), 24'h0, 8'(64 * (i % 3) + i / 3)});
    end
    repeat (4) @(posedge ref_clk);
    chk("fifo empty", 34'(sampleValid), 34'h0);
    apb(1'b1, 16'hA844, 32'h100);
    apb(1'b0, 16'hA844, 32'h0);
    chk("status clear", 34'(rd[8:0]), 34'h0);
    $display("test fifo done");
    report_and_stop();
  end
endmodule
